// [hw/pmr_pkg.sv]
// Purpose: shared constants and types of the management register bank
// Assumes: 16-bit registers addressed by a 5-bit register address
// Notes:   per-register bit-type masks and defaults live here
package pmr_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 5;

  // register addresses
  localparam logic [4:0] ADDR_BASIC_CONTROL      = 5'h00;
  localparam logic [4:0] ADDR_BASIC_STATUS       = 5'h01;
  localparam logic [4:0] ADDR_IDENTIFIER_ONE     = 5'h02;
  localparam logic [4:0] ADDR_IDENTIFIER_TWO     = 5'h03;
  localparam logic [4:0] ADDR_NEG_ADVERTISEMENT  = 5'h04;
  localparam logic [4:0] ADDR_PARTNER_ABILITY    = 5'h05;
  localparam logic [4:0] ADDR_NEG_EXPANSION      = 5'h06;
  localparam logic [4:0] ADDR_NEXT_PAGE_TRANSMIT = 5'h07;
  localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE  = 5'h08;
  localparam logic [4:0] ADDR_STD_LAST           = 5'h08;
  localparam logic [4:0] ADDR_EXTENDED_CONTROL   = 5'h10;
  localparam logic [4:0] ADDR_DETAILED_STATUS    = 5'h11;
  localparam logic [4:0] ADDR_TEN_MBPS_OPS       = 5'h12;
  localparam logic [4:0] ADDR_EXT_CONTROL_SECOND = 5'h13;
  localparam logic [4:0] ADDR_VENDOR_FIRST       = 5'h10;
  localparam logic [4:0] ADDR_VENDOR_LAST        = 5'h13;

  // implemented registers are kept at a dense index 0..12
  localparam int unsigned NUM_REGS = 13;
  localparam int unsigned VENDOR_BASE_IDX = 9;

  localparam logic [15:0] UNMAPPED_READ = 16'hFFFF;

  // field positions
  localparam int unsigned OVERRIDE_ARM_BIT = 15;   // extended control
  localparam int unsigned STRAP_ADDR_LSB   = 6;    // extended control
  localparam int unsigned STRAP_ADDR_W     = 5;
  localparam int unsigned ISOLATE_BIT      = 10;   // basic control
  localparam int unsigned EXT_CTRL_IDX     = 9;

  // per-register bit types: one mask per type, index order as above
  typedef logic [15:0] pmr_word_t;
  typedef pmr_word_t [NUM_REGS-1:0] pmr_table_t;

  // read/write bits; the arm bit 16.15 is one of them, the bank
  // clears it again on the next mapped write, unless that write sets it anew
  localparam pmr_table_t RW_MASK = '{
    16'h0000, 16'h0000, 16'h0000, 16'h87FF,
    16'h07FF, 16'h0000, 16'h0000, 16'h0000,
    16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'hFF80};
  // override-gated bits
  localparam pmr_table_t OGW_MASK = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0040, 16'h0000};
  // write-zero-only bits
  localparam pmr_table_t WZO_MASK = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // bits with a defined default
  localparam pmr_table_t DEF_MASK = '{
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  // default values; strap fields and isolate are filled one edge after reset release
  localparam pmr_table_t DEF_VALUE = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h2001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h7809, 16'h3000};

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pmr_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        hit;
  } pmr_rsp_t;

  typedef struct packed {
    pmr_table_t  regs;
    logic [15:0] rdata;
    logic        hit;
    logic        loaded;
  } pmr_state_t;

endpackage

// [hw/pmr_bank.sv]
// Operation
// [RQ1] standard registers at addresses 0 to 8
// [RQ2] vendor registers at 16 to 19
// [RQ3] read-only bits ignore writes
// [RQ4] override-gated bits blocked while arm bit clear
// [RQ5] armed: next write updates gated, clears arm
// [RQ6] read/write bits take any value
// [RQ7] write-zero-only bits accept only zero
// [RQ8] reset loads every defined default
// [RQ9] bits without default need no value
// [RQ10] strap pins sampled at reset as defaults
// [RQ11] controller never alters reserved test bits
// [RQ12] registers are sixteen bits wide
// [RQ13] unmapped read returns all ones
// [RQ14] unmapped write modifies nothing
// [RQ15] five-bit address selects one of 32
// [RQ16] each bit obeys its own write rule
// [RQ17] writing one to write-zero bit keeps it
//
// Purpose: management register bank behind the serial frame engine
// Assumes: frame engine gives one-cycle read/write strobes on CLK
// Notes:   read data is registered, valid the cycle after the strobe;
//          strap pins are sampled on the first edge after reset release
`timescale 1ns/1ps
module pmr_bank (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST_B,
  // strap pins shared with indicator outputs
  input  wire logic                   STRAP_ADDR0_INDICATOR,
  input  wire logic                   STRAP_ADDR1_INDICATOR,
  input  wire logic                   STRAP_ADDR2_INDICATOR,
  input  wire logic                   STRAP_ADDR3_INDICATOR,
  input  wire logic                   STRAP_ADDR4_INDICATOR,
  // access from the management frame engine
  input  wire pmr_pkg::pmr_req_t      REQ,
  output pmr_pkg::pmr_rsp_t           RSP,
  // register contents to the rest of the device
  output pmr_pkg::pmr_table_t         REGS,
  output logic [4:0]                  DEVICE_ADDR,
  output logic                        STRAPS_LOADED
);

  ////////////////////////////////////////////////////////////////////////
  // state

  pmr_pkg::pmr_state_t state_reg;
  pmr_pkg::pmr_state_t state_next;

  logic [4:0]  strap_pins;
  logic        map_hit;
  logic [3:0]  map_idx;
  logic        arm_set;
  logic [15:0] strap_def;

  assign strap_pins = {STRAP_ADDR4_INDICATOR, STRAP_ADDR3_INDICATOR,
                       STRAP_ADDR2_INDICATOR, STRAP_ADDR1_INDICATOR,
                       STRAP_ADDR0_INDICATOR};

  ////////////////////////////////////////////////////////////////////////
  // address decode: full 5-bit field, dense index for implemented words

  always_comb begin
    map_hit = 1'b0;
    map_idx = 4'h0;
    if (REQ.addr <= pmr_pkg::ADDR_STD_LAST) begin            // [RQ1] [RQ15]
      map_hit = 1'b1;
      map_idx = REQ.addr[3:0];
    end else if (REQ.addr >= pmr_pkg::ADDR_VENDOR_FIRST &&
                 REQ.addr <= pmr_pkg::ADDR_VENDOR_LAST) begin // [RQ2]
      map_hit = 1'b1;
      map_idx = 4'(pmr_pkg::VENDOR_BASE_IDX) + {2'b00, REQ.addr[1:0]};
    end
  end

  assign arm_set =
    state_reg.regs[pmr_pkg::EXT_CTRL_IDX][pmr_pkg::OVERRIDE_ARM_BIT];

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    pmr_pkg::pmr_word_t cur;
    pmr_pkg::pmr_word_t wd;
    pmr_pkg::pmr_word_t keep;
    pmr_pkg::pmr_word_t take;
    cur  = 16'h0000;
    wd   = REQ.wdata;
    keep = 16'h0000;
    take = 16'h0000;
    strap_def = 16'h0000;
    state_next = state_reg;

    // straps land one edge after release; reset itself only loads
    // constants, so pin levels never reach an asynchronous load
    if (!state_reg.loaded) begin
      strap_def = {5'b0_0000, strap_pins, 6'b00_0000};
      state_next.regs[pmr_pkg::EXT_CTRL_IDX] =
        (pmr_pkg::DEF_VALUE[pmr_pkg::EXT_CTRL_IDX] & ~16'h07C0) |
        strap_def;                                           // [RQ10]
      // isolate follows the strapped address: set when address is zero
      state_next.regs[0][pmr_pkg::ISOLATE_BIT] =
        (strap_pins == 5'b0_0000);                           // [RQ10]
      state_next.loaded = 1'b1;
    end else if (REQ.wr && map_hit) begin                    // [RQ14]
      cur = state_reg.regs[map_idx];
      // every bit class is merged independently in one pass
      take = pmr_pkg::RW_MASK[map_idx];                      // [RQ6] [RQ16]
      if (arm_set) begin
        take = take | pmr_pkg::OGW_MASK[map_idx];            // [RQ5]
      end                                                    // [RQ4]
      // write-zero-only: a zero clears, a one leaves the bit as it was
      keep = pmr_pkg::WZO_MASK[map_idx] & wd;                // [RQ7] [RQ17]
      state_next.regs[map_idx] =
        (cur & ~take & ~pmr_pkg::WZO_MASK[map_idx]) |        // [RQ3]
        (wd & take) |
        (cur & keep);                                        // [RQ16]
    end

    // only a write that reaches a register disarms: a discarded
    // one must leave the arm bit as it was
    if (state_reg.loaded && REQ.wr && map_hit && arm_set) begin // [RQ14]
      if (map_idx != 4'(pmr_pkg::EXT_CTRL_IDX)) begin          // [RQ5]
        state_next.regs[pmr_pkg::EXT_CTRL_IDX]
          [pmr_pkg::OVERRIDE_ARM_BIT] = 1'b0;
      end else if (wd[pmr_pkg::OVERRIDE_ARM_BIT] == 1'b1) begin
        // rewriting the arm bit as one re-arms for the following write
        state_next.regs[pmr_pkg::EXT_CTRL_IDX]
          [pmr_pkg::OVERRIDE_ARM_BIT] = 1'b1;
      end else begin
        state_next.regs[pmr_pkg::EXT_CTRL_IDX]
          [pmr_pkg::OVERRIDE_ARM_BIT] = 1'b0;
      end
    end

    // reads: registered, unmapped answers all ones
    // nothing is answered in the cycle that loads the straps
    state_next.hit = REQ.rd && map_hit && state_reg.loaded;
    if (state_reg.loaded && REQ.rd && map_hit) begin
      state_next.rdata = state_reg.regs[map_idx];            // [RQ12]
    end else if (state_reg.loaded && REQ.rd) begin
      state_next.rdata = pmr_pkg::UNMAPPED_READ;             // [RQ13]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers: defaults are constants, reserved test bits keep theirs
  // since no write mask covers them

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg.regs   <= pmr_pkg::DEF_VALUE;                // [RQ8] [RQ9]
      state_reg.rdata  <= 16'h0000;
      state_reg.hit    <= 1'b0;
      state_reg.loaded <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign RSP.rdata     = state_reg.rdata;
  assign RSP.hit       = state_reg.hit;
  assign REGS          = state_reg.regs;
  assign DEVICE_ADDR   = state_reg.regs[pmr_pkg::EXT_CTRL_IDX]
                           [pmr_pkg::STRAP_ADDR_LSB +: 5];
  assign STRAPS_LOADED = state_reg.loaded;

endmodule

// [sim/pmr_bank_checker.sv]
// Purpose: concurrent checks on the register bank ports
// Assumes: one clock, async active-low reset
// Notes:   bound to every pmr_bank instance
`timescale 1ns/1ps
module pmr_bank_checker (
  // clock and reset
  input wire logic                CLK,
  input wire logic                RST_B,
  // strap pins
  input wire logic                STRAP_ADDR0_INDICATOR,
  input wire logic                STRAP_ADDR1_INDICATOR,
  input wire logic                STRAP_ADDR2_INDICATOR,
  input wire logic                STRAP_ADDR3_INDICATOR,
  input wire logic                STRAP_ADDR4_INDICATOR,
  // access and contents
  input wire pmr_pkg::pmr_req_t   REQ,
  input wire pmr_pkg::pmr_rsp_t   RSP,
  input wire pmr_pkg::pmr_table_t REGS,
  input wire logic [4:0]          DEVICE_ADDR,
  input wire logic                STRAPS_LOADED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic        mapped;
  logic        armed;
  logic        arm_wr;
  logic [15:0] sel;
  logic [15:0] gated;
  logic [4:0]  pins;
  assign mapped = REQ.addr <= 5'h08 ||
                  (REQ.addr >= 5'h10 && REQ.addr <= 5'h13);
  assign sel = REGS[REQ.addr <= 5'h08 ? REQ.addr : REQ.addr - 5'h07];
  assign armed = REGS[9][15];
  assign arm_wr = REQ.addr == 5'h10 && REQ.wdata[15];
  assign gated = REGS[1] & pmr_pkg::OGW_MASK[1];
  assign pins = {STRAP_ADDR4_INDICATOR, STRAP_ADDR3_INDICATOR,
                 STRAP_ADDR2_INDICATOR, STRAP_ADDR1_INDICATOR,
                 STRAP_ADDR0_INDICATOR};
  sequence s_read;  REQ.rd && STRAPS_LOADED; endsequence
  sequence s_write; REQ.wr && STRAPS_LOADED; endsequence
  chk_read_data: assert property (s_read ##0 mapped |=>
    RSP.rdata == $past(sel) && RSP.hit) else $error("bad read data");
  chk_unmapped_read: assert property (s_read ##0 !mapped |=>
    RSP.rdata == 16'hFFFF && !RSP.hit) else $error("bad unmapped read");
  chk_hit_cause: assert property (RSP.hit |->
    $past(REQ.rd && mapped && STRAPS_LOADED)) else $error("stray hit");
  chk_unmapped_write: assert property (s_write ##0 !mapped |=>
    $stable(REGS)) else $error("unmapped write changed a register");
  chk_idle_stable: assert property (STRAPS_LOADED && !REQ.wr |=>
    $stable(REGS)) else $error("registers moved without a write");
  chk_gate_blocked: assert property (s_write ##0 !armed |=>
    $stable(gated)) else $error("gated bit written while disarmed");
  chk_arm_sets: assert property (s_write ##0 arm_wr |=> armed)
    else $error("arm bit not set");
  chk_arm_clears: assert property (s_write ##0 mapped && armed &&
    !arm_wr |=> !armed) else $error("arm bit not cleared");
  chk_strap_load: assert property ($rose(STRAPS_LOADED) |->
    DEVICE_ADDR == $past(pins) && REGS[0][10] == (DEVICE_ADDR == 5'h00))
    else $error("strap default wrong");
endmodule
bind pmr_bank pmr_bank_checker i_chk (.CLK(CLK), .RST_B(RST_B),
  .STRAP_ADDR0_INDICATOR(STRAP_ADDR0_INDICATOR),
  .STRAP_ADDR1_INDICATOR(STRAP_ADDR1_INDICATOR),
  .STRAP_ADDR2_INDICATOR(STRAP_ADDR2_INDICATOR),
  .STRAP_ADDR3_INDICATOR(STRAP_ADDR3_INDICATOR),
  .STRAP_ADDR4_INDICATOR(STRAP_ADDR4_INDICATOR), .REQ(REQ), .RSP(RSP),
  .REGS(REGS), .DEVICE_ADDR(DEVICE_ADDR), .STRAPS_LOADED(STRAPS_LOADED));

// [sim/pmr_sta_model.sv]
// Purpose: station management side issuing single register accesses
// Assumes: access taken on a rising edge, answer one cycle later
// Notes:   released lines carry inverted values so stale data is not seen
`timescale 1ns/1ps
module pmr_sta_model (
  // clock
  input wire logic              CLK,
  // management access
  output pmr_pkg::pmr_req_t     REQ,
  input wire pmr_pkg::pmr_rsp_t RSP
);
  initial REQ = '0;
  // reserved bits are written only as the caller passes them
  task automatic acc(input logic r, input logic w, input logic [4:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge CLK);
    #1 REQ = {r, w, a, d};
    @(posedge CLK);
    #1 REQ = {2'b00, ~a, ~d};
    q = RSP.rdata;
  endtask
endmodule

// [sim/phy_management_register_bank_test.sv]
// Purpose: directed tests of the management register bank
// Assumes: masks and defaults of pmr_pkg describe the bit types
// Notes:   a reference copy of the bank is kept in m
`timescale 1ns/1ps
module phy_management_register_bank_test;
  logic               clk = 0;
  logic               rst_b = 0;
  logic [4:0]         strap = 5'h16;
  pmr_pkg::pmr_req_t  req;
  pmr_pkg::pmr_rsp_t  rsp;
  pmr_pkg::pmr_table_t regs, m;
  logic [4:0]         dev;
  logic               loaded;
  logic [15:0]        q;
  int                 n_errors = 0, checked = 0;
  always #20 clk = ~clk;
  pmr_bank i_dut (.CLK(clk), .RST_B(rst_b), .STRAP_ADDR0_INDICATOR(strap[0]),
    .STRAP_ADDR1_INDICATOR(strap[1]), .STRAP_ADDR2_INDICATOR(strap[2]),
    .STRAP_ADDR3_INDICATOR(strap[3]), .STRAP_ADDR4_INDICATOR(strap[4]),
    .REQ(req), .RSP(rsp), .REGS(regs), .DEVICE_ADDR(dev),
    .STRAPS_LOADED(loaded));
  pmr_sta_model i_sta (.CLK(clk), .REQ(req), .RSP(rsp));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic int ix(input logic [4:0] a);
    return a <= 5'h08 ? int'(a) : int'(a) - 7;
  endfunction
  function automatic logic hit(input logic [4:0] a);
    return a <= 5'h08 || (a >= 5'h10 && a <= 5'h13);
  endfunction
  task automatic do_reset(input logic [4:0] s);
    strap = s;
    rst_b = 0;
    repeat (16) @(posedge clk);
    #1 rst_b = 1;
    m = pmr_pkg::DEF_VALUE;
    m[9][10:6] = s;
    m[0][10] = (s == 5'h00);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, loaded}, 16'h0001);
    for (int i = 0; i < 13; i++) chk(regs[i] & pmr_pkg::DEF_MASK[i],
      m[i] & pmr_pkg::DEF_MASK[i]);
    chk({11'h000, dev}, {11'h000, s});
  endtask
  // the model keeps the arm bit by hand: it is not a plain writable bit
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] wm;
    i_sta.acc(1'b0, 1'b1, a, d, q);
    if (hit(a)) begin
      wm = pmr_pkg::RW_MASK[ix(a)];
      if (m[9][15]) wm |= pmr_pkg::OGW_MASK[ix(a)];
      m[ix(a)] = (m[ix(a)] & ~wm) | (d & wm);
      m[ix(a)] &= ~(pmr_pkg::WZO_MASK[ix(a)] & ~d);
      m[9][15] = (a == 5'h10) && d[15];
    end
    for (int i = 0; i < 13; i++) chk(regs[i], m[i]);
  endtask
  task automatic t_map;
    for (int a = 0; a < 32; a++) begin
      i_sta.acc(1'b1, 1'b0, 5'(a), 16'h0000, q);
      chk(q, hit(5'(a)) ? m[ix(5'(a))] : 16'hFFFF);
      chk({15'h0000, rsp.hit}, {15'h0000, hit(5'(a))});
      if (!hit(5'(a))) wr(5'(a), 16'hFFFF);
    end
    $display("done map");
  endtask
  task automatic t_bits;
    for (int a = 0; a < 20; a++) begin
      if (hit(5'(a))) begin
        wr(5'(a), 16'hFFFF);
        wr(5'(a), 16'h0000);
      end
    end
    $display("done bits");
  endtask
  task automatic t_arm;
    wr(5'h01, 16'h0040);
    wr(5'h10, 16'h8000);
    wr(5'h01, 16'h0040);
    chk(regs[9], m[9]);
    i_sta.acc(1'b1, 1'b0, 5'h01, 16'h0000, q);
    chk(q, m[1]);
    $display("done arm");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    n_errors++;
    report_and_stop;
  end
  initial begin
    do_reset(5'h16);
    do_reset(5'h00);
    $display("done defaults");
    t_map;
    t_bits;
    t_arm;
    report_and_stop;
  end
endmodule
